/* File: rtc_pkg.sv */
// Constants, types and register map of the reset trigger conduction block.
// Assumes one 100 MHz clock and a plain address/strobe register port.
// Overview of operation
// RL1 - trigger makes reset only if enabled and winning
// RL2 - every trigger maskable except power-on trigger
// RL3 - user triggers gated and typed by config registers
// RL4 - power triggers enabled by monitor/watchdog control bits
// RL5 - power resets assert asynchronously, no clock needed
// RL6 - user resets generated synchronously on system clock
// RL7 - reset types ranked priority one to five
// RL8 - any reset also activates all lower types
// RL9 - software reset by register bit or instruction
// RL10 - pin and internal triggers arbitrated before assertion
// RL11 - winning trigger asserts reset of its target group
// RL12 - several active reset phases in one conduction
// RL13 - hardware ramp-up follows power-class reset release
// RL14 - conduction ends with type-specific startup firmware
// RL15 - power reset restores base-mode clock and supply
// RL16 - user reset keeps clock and supply settings
// RL17 - power-on reset follows low level on pin
// RL18 - order: por, standby+core, core, internal, application
// RL19 - simultaneous triggers: highest type wins, rest cascade
`default_nettype none

package rtc_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int USER_ACT_NS = 100;
   localparam int USER_ACT_CYC = (USER_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWR_REL_NS = 50;
   localparam int PWR_REL_CYC = (PWR_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int NUM_PWR = 3;
   localparam int EXT_USER_TRIGS = 3;

   localparam logic [3:0] OFS_USER_CFG = 4'h0;
   localparam logic [3:0] OFS_MON_CTRL = 4'h1;
   localparam logic [3:0] OFS_WDOG_CTRL = 4'h2;
   localparam logic [3:0] OFS_SW_CTRL = 4'h3;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_TRIG_SEEN = 4'h5;

   localparam int CFG_EN_BIT = 0;
   localparam int CFG_TYPE_BIT = 1;
   localparam int MON_STBY_EN_BIT = 0;
   localparam int MON_CORE_EN_BIT = 1;
   localparam int WDOG_EN_BIT = 0;
   localparam int SW_TRIG_BIT = 0;
   localparam int STAT_LAST_LSB = 0;
   localparam int STAT_CUR_LSB = 4;
   localparam int STAT_STATE_LSB = 8;
   localparam int SEEN_PWR_LSB = 0;
   localparam int SEEN_USER_LSB = 8;

   localparam logic [15:0] USER_CFG_RST = 16'h0000;
   localparam logic [15:0] MON_CTRL_RST = 16'h0003;
   localparam logic [15:0] WDOG_CTRL_RST = 16'h0001;

   typedef logic [2:0] rtc_level_t;
   localparam rtc_level_t LVL_NONE = 3'h0;
   localparam rtc_level_t LVL_POR = 3'h1;
   localparam rtc_level_t LVL_STBY = 3'h2;
   localparam rtc_level_t LVL_CORE = 3'h3;
   localparam rtc_level_t LVL_INTAPP = 3'h4;
   localparam rtc_level_t LVL_APP = 3'h5;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PWR_ACT = 5'h02,
      ST_USER_ACT = 5'h04,
      ST_RAMP = 5'h08,
      ST_FIRM = 5'h10
   } rtc_state_t;

   typedef struct packed {
      logic porPinN;
      logic monStandbyFail;
      logic monCoreFail;
      logic wdogSupplyFail;
   } rtc_pwr_trig_t;

   typedef struct packed {
      logic start;
      rtc_level_t level;
   } rtc_fw_req_t;

endpackage

`default_nettype wire

/* File: rtc_pwr_rst_cell.sv */
// One power-class reset output: set with no clock, released on the clock.
// Assumes the set input is a glitch-free level from supply monitors or pin.
`default_nettype none

module rtc_pwr_rst_cell #(
   parameter int HOLD_CYC = rtc_pkg::PWR_REL_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic setIn,
   output logic rstOut
);

   localparam int CNT_W = $clog2(HOLD_CYC + 1);
   localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYC);

   logic setAsync;
   logic [CNT_W-1:0] holdCnt_q;

   assign setAsync = rst | setIn;

   // assertion needs no clock edge; release waits a short hold so targets see
   // a clean edge once the trigger has gone
   always_ff @(posedge clk or posedge setAsync) begin
      if (setAsync) begin
         rstOut <= 1'b1; // RL5
         holdCnt_q <= HOLD_LD;
      end else if (holdCnt_q != '0) begin
         holdCnt_q <= holdCnt_q - 1'b1;
      end else begin
         rstOut <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: rtc_reset_ctrl.sv */
// Reset trigger gating, arbitration and conduction sequencer.
// Assumes trigger inputs are levels; register port answers reads next cycle.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`default_nettype none

module rtc_reset_ctrl #(
   parameter int USER_TRIGS = rtc_pkg::EXT_USER_TRIGS,
   parameter int USER_ACT_CYC = rtc_pkg::USER_ACT_CYC,
   parameter int PWR_HOLD_CYC = rtc_pkg::PWR_REL_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [rtc_pkg::ADDR_W-1:0] addr,
   input wire logic [rtc_pkg::DATA_W-1:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [rtc_pkg::DATA_W-1:0] rdData,
   input wire rtc_pkg::rtc_pwr_trig_t pwrTrig,
   input wire logic [USER_TRIGS-1:0] userTrig,
   input wire logic swResetInstr,
   input wire logic rampDone,
   input wire logic fwDone,
   output logic [rtc_pkg::NUM_PWR-1:0] pwrRst,
   output logic intAppRst,
   output logic appRst,
   output logic rampUpEn,
   output rtc_pkg::rtc_fw_req_t fwReq,
   output logic clkSupplyDefault,
   output logic clkCfgKeep
);

   localparam int ALL_TRIGS = USER_TRIGS + 1;
   localparam int CNT_W = $clog2(USER_ACT_CYC + 1);
   localparam logic [CNT_W-1:0] ACT_LD = CNT_W'(USER_ACT_CYC);

   // registers
   logic [15:0] userCfg_q;
   logic [15:0] monCtrl_q;
   logic [15:0] wdogCtrl_q;
   logic swReq_q;
   logic [3:0] pwrSeen_q;
   logic [ALL_TRIGS-1:0] userSeen_q;
   rtc_pkg::rtc_level_t lastLvl_q;

   // sequencer
   rtc_pkg::rtc_state_t stateQ;
   rtc_pkg::rtc_state_t stateD;
   rtc_pkg::rtc_level_t lvlQ;
   rtc_pkg::rtc_level_t lvlD;
   logic [CNT_W-1:0] cntQ;
   logic [CNT_W-1:0] cntD;

   // power reset path
   logic gateStby;
   logic gateCore;
   logic [rtc_pkg::NUM_PWR-1:0] pwrSet;
   logic [rtc_pkg::NUM_PWR-1:0] pwrMeta_q;
   logic [rtc_pkg::NUM_PWR-1:0] pwrSync_q;
   rtc_pkg::rtc_level_t pwrHigh;

   // user arbitration
   logic [ALL_TRIGS-1:0] allTrig;
   logic [ALL_TRIGS-1:0] reqInt;
   logic [ALL_TRIGS-1:0] reqApp;
   rtc_pkg::rtc_level_t userLvl;

   logic wrUserCfg;
   logic wrMonCtrl;
   logic wrWdogCtrl;
   logic wrSw;
   logic wrSeen;
   logic userTaken;
   logic fwEntry;
   logic pwrCfgClear;

   assign wrUserCfg = wrEn && (addr == rtc_pkg::OFS_USER_CFG);
   assign wrMonCtrl = wrEn && (addr == rtc_pkg::OFS_MON_CTRL);
   assign wrWdogCtrl = wrEn && (addr == rtc_pkg::OFS_WDOG_CTRL);
   assign wrSw = wrEn && (addr == rtc_pkg::OFS_SW_CTRL);
   assign wrSeen = wrEn && (addr == rtc_pkg::OFS_TRIG_SEEN);

   // ---------------------------------------------------------------
   // power-class triggers: gating is combinational so the reset can
   // reach its target while the clock is stopped
   // ---------------------------------------------------------------
   assign gateStby = (pwrTrig.monStandbyFail && monCtrl_q[rtc_pkg::MON_STBY_EN_BIT])
      || (pwrTrig.wdogSupplyFail && wdogCtrl_q[rtc_pkg::WDOG_EN_BIT]); // RL4
   assign gateCore = pwrTrig.monCoreFail && monCtrl_q[rtc_pkg::MON_CORE_EN_BIT]; // RL4

   // power-on pin is never gated by any register bit
   assign pwrSet[0] = !pwrTrig.porPinN; // RL2 RL17
   // each level also fires for every higher-ranked trigger
   assign pwrSet[1] = pwrSet[0] || gateStby; // RL8
   assign pwrSet[2] = pwrSet[1] || gateCore; // RL8

   genvar gp;
   generate
      for (gp = 0; gp < rtc_pkg::NUM_PWR; gp++) begin : g_pwr
         rtc_pwr_rst_cell #(
            .HOLD_CYC(PWR_HOLD_CYC)
         ) u_cell (
            .clk(clk),
            .rst(rst),
            .setIn(pwrSet[gp]),
            .rstOut(pwrRst[gp])
         ); // RL5 RL11
      end
   endgenerate

   // bring the asynchronous power resets into the sequencer's domain
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwrMeta_q <= '0;
         pwrSync_q <= '0;
      end else begin
         pwrMeta_q <= pwrRst;
         pwrSync_q <= pwrMeta_q;
      end
   end

   // cascade means a lower index implies all higher ones
   always_comb begin
      if (pwrSync_q[0]) begin
         pwrHigh = rtc_pkg::LVL_POR; // RL18
      end else if (pwrSync_q[1]) begin
         pwrHigh = rtc_pkg::LVL_STBY; // RL18
      end else if (pwrSync_q[2]) begin
         pwrHigh = rtc_pkg::LVL_CORE; // RL18
      end else begin
         pwrHigh = rtc_pkg::LVL_NONE;
      end
   end

   // ---------------------------------------------------------------
   // user-class triggers: index 0 is software, the rest are inputs
   // ---------------------------------------------------------------
   assign allTrig = {userTrig, swReq_q}; // RL9 RL10

   genvar gu;
   generate
      for (gu = 0; gu < ALL_TRIGS; gu++) begin : g_user
         logic en;
         logic typeInt;
         assign en = userCfg_q[2 * gu + rtc_pkg::CFG_EN_BIT];
         assign typeInt = userCfg_q[2 * gu + rtc_pkg::CFG_TYPE_BIT];
         assign reqInt[gu] = allTrig[gu] && en && typeInt; // RL1 RL3
         assign reqApp[gu] = allTrig[gu] && en && !typeInt; // RL1 RL3
      end
   endgenerate

   always_comb begin
      if (|reqInt) begin
         userLvl = rtc_pkg::LVL_INTAPP; // RL19
      end else if (|reqApp) begin
         userLvl = rtc_pkg::LVL_APP; // RL19
      end else begin
         userLvl = rtc_pkg::LVL_NONE;
      end
   end

   // ---------------------------------------------------------------
   // conduction sequencer
   // ---------------------------------------------------------------
   always_comb begin
      stateD = stateQ;
      lvlD = lvlQ;
      cntD = cntQ;
      if (pwrHigh != rtc_pkg::LVL_NONE) begin
         // power resets pre-empt any phase, a higher one raises the level
         stateD = rtc_pkg::ST_PWR_ACT; // RL7 RL19
         if (stateQ != rtc_pkg::ST_PWR_ACT || pwrHigh < lvlQ) begin
            lvlD = pwrHigh;
         end
      end else begin
         unique case (stateQ)
            rtc_pkg::ST_IDLE: begin
               if (userLvl != rtc_pkg::LVL_NONE) begin
                  stateD = rtc_pkg::ST_USER_ACT; // RL10 RL11
                  lvlD = userLvl;
                  cntD = ACT_LD;
               end
            end
            rtc_pkg::ST_PWR_ACT: begin
               // second active phase: user resets outlast the power one
               stateD = rtc_pkg::ST_USER_ACT; // RL12
               cntD = ACT_LD;
            end
            rtc_pkg::ST_USER_ACT: begin
               if (cntQ == '0) begin
                  stateD = rtc_pkg::ST_RAMP;
               end else begin
                  cntD = cntQ - 1'b1;
               end
            end
            rtc_pkg::ST_RAMP: begin
               if (lvlQ > rtc_pkg::LVL_CORE || rampDone) begin
                  stateD = rtc_pkg::ST_FIRM; // RL13
               end
            end
            rtc_pkg::ST_FIRM: begin
               if (fwDone) begin
                  stateD = rtc_pkg::ST_IDLE; // RL14
               end
            end
            default: begin
               stateD = rtc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateQ <= rtc_pkg::ST_IDLE;
         lvlQ <= rtc_pkg::LVL_NONE;
         cntQ <= '0;
      end else begin
         stateQ <= stateD;
         lvlQ <= lvlD;
         cntQ <= cntD;
      end
   end

   assign userTaken = (stateQ == rtc_pkg::ST_IDLE) && (stateD == rtc_pkg::ST_USER_ACT);
   assign fwEntry = (stateD == rtc_pkg::ST_FIRM) && (stateQ != rtc_pkg::ST_FIRM);
   // settings live in the standby domain, so only its resets wipe them
   assign pwrCfgClear = (stateQ == rtc_pkg::ST_PWR_ACT) && (lvlQ <= rtc_pkg::LVL_STBY);

   // ---------------------------------------------------------------
   // user reset outputs, clocked by design: no clock means no user reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intAppRst <= 1'b1;
         appRst <= 1'b1;
      end else begin
         intAppRst <= (stateD == rtc_pkg::ST_PWR_ACT)
            || (stateD == rtc_pkg::ST_USER_ACT && lvlD <= rtc_pkg::LVL_INTAPP); // RL6 RL8
         appRst <= (stateD == rtc_pkg::ST_PWR_ACT)
            || (stateD == rtc_pkg::ST_USER_ACT); // RL6 RL8
      end
   end

   // hardware ramp-up after power-class resets only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rampUpEn <= 1'b0;
      end else begin
         rampUpEn <= (stateD == rtc_pkg::ST_RAMP) && (lvlD <= rtc_pkg::LVL_CORE); // RL13
      end
   end

   // firmware hand-off and clock/supply treatment
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fwReq <= '0;
         clkSupplyDefault <= 1'b0;
         clkCfgKeep <= 1'b0;
      end else begin
         fwReq.start <= fwEntry; // RL14
         if (fwEntry) begin
            fwReq.level <= lvlD;
         end
         clkSupplyDefault <= fwEntry && (lvlD <= rtc_pkg::LVL_CORE); // RL15
         // held across the whole user conduction so firmware leaves
         // clock and supply untouched
         clkCfgKeep <= (stateD != rtc_pkg::ST_IDLE)
            && (stateD != rtc_pkg::ST_PWR_ACT)
            && (lvlD >= rtc_pkg::LVL_INTAPP); // RL16
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lastLvl_q <= rtc_pkg::LVL_NONE;
      end else if (stateQ == rtc_pkg::ST_FIRM && fwDone && pwrHigh == rtc_pkg::LVL_NONE) begin
         lastLvl_q <= lvlQ;
      end
   end

   // ---------------------------------------------------------------
   // software-visible registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         userCfg_q <= rtc_pkg::USER_CFG_RST;
      end else if (pwrCfgClear) begin
         userCfg_q <= rtc_pkg::USER_CFG_RST;
      end else if (wrUserCfg) begin
         userCfg_q <= wrData; // RL3
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         monCtrl_q <= rtc_pkg::MON_CTRL_RST;
         wdogCtrl_q <= rtc_pkg::WDOG_CTRL_RST;
      end else if (pwrCfgClear) begin
         monCtrl_q <= rtc_pkg::MON_CTRL_RST;
         wdogCtrl_q <= rtc_pkg::WDOG_CTRL_RST;
      end else begin
         if (wrMonCtrl) begin
            monCtrl_q <= wrData; // RL4
         end
         if (wrWdogCtrl) begin
            wdogCtrl_q <= wrData; // RL4
         end
      end
   end

   // software request stays pending until the arbiter takes it; a new
   // request in the taking cycle wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         swReq_q <= 1'b0;
      end else if ((wrSw && wrData[rtc_pkg::SW_TRIG_BIT]) || swResetInstr) begin
         swReq_q <= 1'b1; // RL9
      end else if (userTaken) begin
         swReq_q <= 1'b0;
      end
   end

   // trigger events are logged whether or not they are enabled, which
   // lets software tell a masked trigger from one that reset the part
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwrSeen_q <= '0;
         userSeen_q <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (pwrTrig[3 - i] ^ (i == 0)) begin
               pwrSeen_q[i] <= 1'b1; // RL1
            end else if (wrSeen && wrData[rtc_pkg::SEEN_PWR_LSB + i]) begin
               pwrSeen_q[i] <= 1'b0;
            end
         end
         for (int j = 0; j < ALL_TRIGS; j++) begin
            if (allTrig[j]) begin
               userSeen_q[j] <= 1'b1; // RL1
            end else if (wrSeen && wrData[rtc_pkg::SEEN_USER_LSB + j]) begin
               userSeen_q[j] <= 1'b0;
            end
         end
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= '0;
      end else if (rdEn) begin
         unique case (addr)
            rtc_pkg::OFS_USER_CFG: rdData <= userCfg_q;
            rtc_pkg::OFS_MON_CTRL: rdData <= monCtrl_q;
            rtc_pkg::OFS_WDOG_CTRL: rdData <= wdogCtrl_q;
            rtc_pkg::OFS_SW_CTRL: rdData <= {15'h0000, swReq_q};
            rtc_pkg::OFS_STATUS: begin
               rdData <= '0;
               rdData[rtc_pkg::STAT_LAST_LSB +: 3] <= lastLvl_q;
               rdData[rtc_pkg::STAT_CUR_LSB +: 3] <= lvlQ;
               rdData[rtc_pkg::STAT_STATE_LSB +: 5] <= stateQ;
            end
            rtc_pkg::OFS_TRIG_SEEN: begin
               rdData <= '0;
               rdData[rtc_pkg::SEEN_PWR_LSB +: 4] <= pwrSeen_q;
               rdData[rtc_pkg::SEEN_USER_LSB +: ALL_TRIGS] <= userSeen_q;
            end
            default: rdData <= '0;
         endcase
      end else begin
         rdData <= '0;
      end
   end

endmodule

`default_nettype wire

/* File: rtc_reset_ctrl_sva.sv */
// Concurrent checks on the ports of the reset trigger conduction block.
// Assumes a single clock domain with rst asynchronous and active high.
`default_nettype none

module rtc_reset_ctrl_sva #(
   parameter int USER_ACT_CYC = rtc_pkg::USER_ACT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rdEn,
   input wire logic [rtc_pkg::DATA_W-1:0] rdData,
   input wire rtc_pkg::rtc_pwr_trig_t pwrTrig,
   input wire logic [rtc_pkg::NUM_PWR-1:0] pwrRst,
   input wire logic intAppRst,
   input wire logic appRst,
   input wire logic rampUpEn,
   input wire logic rampDone,
   input wire rtc_pkg::rtc_fw_req_t fwReq,
   input wire logic clkSupplyDefault,
   input wire logic clkCfgKeep
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ACT_MAX = USER_ACT_CYC + 4;
   localparam int RAMP_MAX = USER_ACT_CYC + 12;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_POR_PIN: assert property (!pwrTrig.porPinN |-> pwrRst == 3'h7)
      else $error("power-on pin low without full power reset");
   AST_PWR_CASCADE: assert property (pwrRst[0] |-> pwrRst[1] && pwrRst[2])
      else $error("power reset without its lower power types");
   AST_STBY_CASCADE: assert property (pwrRst[1] |-> pwrRst[2])
      else $error("standby and core reset without core reset");
   AST_USER_CASCADE: assert property (intAppRst |-> appRst)
      else $error("internal application reset without application reset");
   AST_USER_LEN: assert property ($rose(appRst) && clkCfgKeep |->
      appRst [*2] ##[0:ACT_MAX] !appRst)
      else $error("user reset active phase length wrong");
   AST_RAMP_AFTER_PWR: assert property ($fell(pwrRst[2]) |-> ##[1:RAMP_MAX] rampUpEn)
      else $error("no ramp-up after power reset release");
   AST_RAMP_HOLD: assert property (rampUpEn && !rampDone && pwrRst == 3'h0 |=> rampUpEn)
      else $error("ramp-up request dropped before done");
   AST_FW_PULSE: assert property (fwReq.start |=> !fwReq.start)
      else $error("firmware start longer than one cycle");
   AST_USER_FW_TYPE: assert property (fwReq.start && clkCfgKeep |-> fwReq.level >= 3'h4)
      else $error("user conduction reports a power type");
   AST_KEEP_NO_DEFAULT: assert property (clkCfgKeep |-> !clkSupplyDefault)
      else $error("base-mode load during user conduction");
   AST_RD_IDLE: assert property (!$past(rdEn) |-> rdData == 16'h0000)
      else $error("read data outside its cycle");
endmodule

bind rtc_reset_ctrl rtc_reset_ctrl_sva #(.USER_ACT_CYC(USER_ACT_CYC)) i_rtc_reset_ctrl_sva (
   .clk(clk), .rst(rst), .rdEn(rdEn), .rdData(rdData), .pwrTrig(pwrTrig), .pwrRst(pwrRst),
   .intAppRst(intAppRst), .appRst(appRst), .rampUpEn(rampUpEn), .rampDone(rampDone),
   .fwReq(fwReq), .clkSupplyDefault(clkSupplyDefault), .clkCfgKeep(clkCfgKeep));

`default_nettype wire

/* File: rtc_trig_partner.sv */
// Far-side model: supply ramp-up unit and startup firmware answering the sequencer.
// Assumes rampUpEn is a level and fwStart a one-cycle pulse on clk.
`default_nettype none

module rtc_trig_partner (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic rampUpEn,
   input wire logic fwStart,
   output logic rampDone,
   output logic fwDone
);
   timeunit 1ns;
   timeprecision 1ps;
   int rampCnt;
   int fwCnt;
   logic fwBusy;
   int dly;
   assign dly = slow ? 12 : 1;

   // ramp done only once the supply had time to settle; dropped with the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rampCnt <= 0;
         rampDone <= 1'b0;
      end else if (!rampUpEn) begin
         rampCnt <= 0;
         rampDone <= 1'b0;
      end else if (rampCnt >= dly) begin
         rampDone <= 1'b1;
      end else begin
         rampCnt <= rampCnt + 1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fwBusy <= 1'b0;
         fwCnt <= 0;
         fwDone <= 1'b0;
      end else begin
         fwDone <= 1'b0;
         if (fwStart) begin
            fwBusy <= 1'b1;
            fwCnt <= 0;
         end else if (fwBusy && fwCnt >= dly) begin
            fwDone <= 1'b1;
            fwBusy <= 1'b0;
         end else if (fwBusy) begin
            fwCnt <= fwCnt + 1;
         end
      end
   end
endmodule

`default_nettype wire

/* File: rtc_reset_ctrl_tb.sv */
// Self-checking bench for the reset trigger conduction block.
// Assumes the partner model answers ramp-up and firmware requests.
`default_nettype none

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failCount++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module rtc_reset_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wrData = 16'h0000;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic [15:0] rdData;
   rtc_pkg::rtc_pwr_trig_t pwrTrig = 4'h8;
   logic [2:0] userTrig = 3'h0;
   logic swResetInstr = 1'b0;
   logic slow = 1'b0;
   logic rampDone, fwDone, intAppRst, appRst, rampUpEn, clkSupplyDefault, clkCfgKeep;
   logic [2:0] pwrRst;
   rtc_pkg::rtc_fw_req_t fwReq;
   rtc_pkg::rtc_level_t lastLvl = 3'h0;
   int defCnt = 0;
   int rampSeen = 0;
   int failCount = 0;
   int compares = 0;

   always #5 clk = ~clk;

   rtc_reset_ctrl #(.USER_ACT_CYC(2), .PWR_HOLD_CYC(1)) i_rtc_reset_ctrl (
      .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
      .rdData(rdData), .pwrTrig(pwrTrig), .userTrig(userTrig), .swResetInstr(swResetInstr),
      .rampDone(rampDone), .fwDone(fwDone), .pwrRst(pwrRst), .intAppRst(intAppRst),
      .appRst(appRst), .rampUpEn(rampUpEn), .fwReq(fwReq),
      .clkSupplyDefault(clkSupplyDefault), .clkCfgKeep(clkCfgKeep));

   rtc_trig_partner i_rtc_trig_partner (.clk(clk), .rst(rst), .slow(slow),
      .rampUpEn(rampUpEn), .fwStart(fwReq.start), .rampDone(rampDone), .fwDone(fwDone));

   always @(posedge clk) begin
      if (fwReq.start === 1'b1) lastLvl <= fwReq.level;
      if (clkSupplyDefault === 1'b1) defCnt <= defCnt + 1;
      if (rampUpEn === 1'b1) rampSeen <= rampSeen + 1;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 d = rdData;
   endtask

   // polls the state field; the sequencer must come back to idle within the bound
   task automatic wait_idle();
      logic [15:0] v;
      int n;
      n = 0;
      v = 16'h0000;
      while (v[12:8] !== 5'h01 && n < 200) begin
         rd(rtc_pkg::OFS_STATUS, v);
         n++;
      end
      `CHK("idle state", 5'h01, v[12:8])
   endtask

   task automatic wait_app();
      int n;
      n = 0;
      while (appRst !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      #1 `CHK("appRst rise", 1'b1, appRst)
   endtask

   task automatic t_regs();
      logic [15:0] v;
      rd(rtc_pkg::OFS_USER_CFG, v); `CHK("cfg reset", rtc_pkg::USER_CFG_RST, v)
      rd(rtc_pkg::OFS_MON_CTRL, v); `CHK("mon reset", rtc_pkg::MON_CTRL_RST, v)
      rd(rtc_pkg::OFS_WDOG_CTRL, v); `CHK("wdog reset", rtc_pkg::WDOG_CTRL_RST, v)
      rd(4'hF, v); `CHK("unmapped", 16'h0000, v)
   endtask

   task automatic t_sw_reg();
      int bad, d0, r0;
      logic [15:0] v;
      bad = 0;
      d0 = defCnt;
      r0 = rampSeen;
      wr(rtc_pkg::OFS_SW_CTRL, 16'h0001);
      repeat (15) begin
         @(posedge clk);
         if (appRst !== 1'b0) bad++;
      end
      `CHK("disabled sw trigger", 0, bad)
      wr(rtc_pkg::OFS_USER_CFG, 16'h0001);
      wait_app();
      `CHK("type5 only", 1'b0, intAppRst)
      `CHK("keep clock cfg", 1'b1, clkCfgKeep)
      wait_idle();
      `CHK("fw level sw", 3'h5, lastLvl)
      `CHK("no base load", 0, defCnt - d0)
      `CHK("no ramp user", 0, rampSeen - r0)
      rd(rtc_pkg::OFS_STATUS, v); `CHK("last type", 3'h5, v[2:0])
   endtask

   task automatic t_user_prio();
      wr(rtc_pkg::OFS_USER_CFG, 16'h0034);
      slow <= 1'b1;
      @(posedge clk);
      userTrig <= 3'h3;
      wait_app();
      `CHK("type4 wins", 1'b1, intAppRst)
      @(posedge clk);
      userTrig <= 3'h0;
      wait_idle();
      `CHK("fw level prio", 3'h4, lastLvl)
      slow <= 1'b0;
      wr(rtc_pkg::OFS_USER_CFG, 16'h0001);
      @(posedge clk);
      swResetInstr <= 1'b1;
      @(posedge clk);
      swResetInstr <= 1'b0;
      wait_app();
      `CHK("instr type5", 1'b0, intAppRst)
      wait_idle();
      `CHK("fw level instr", 3'h5, lastLvl)
   endtask

   task automatic t_pwr(input int b, input logic [2:0] e, input logic [2:0] l);
      int d0, r0;
      d0 = defCnt;
      r0 = rampSeen;
      @(posedge clk);
      pwrTrig[b] <= (b == 3) ? 1'b0 : 1'b1;
      #1 `CHK("pwrRst async", e, pwrRst)
      repeat (8) @(posedge clk);
      #1 `CHK("pwrRst held", e, pwrRst)
      @(posedge clk);
      pwrTrig <= 4'h8;
      wait_idle();
      `CHK("fw level pwr", l, lastLvl)
      `CHK("base mode load", 1, (defCnt - d0) > 0)
      `CHK("ramp after power", 1, (rampSeen - r0) > 0)
   endtask

   task automatic t_mask();
      logic [15:0] v;
      wr(rtc_pkg::OFS_MON_CTRL, 16'h0000);
      wr(rtc_pkg::OFS_WDOG_CTRL, 16'h0000);
      wr(rtc_pkg::OFS_TRIG_SEEN, 16'h0F0F);
      rd(rtc_pkg::OFS_TRIG_SEEN, v); `CHK("seen clear", 16'h0000, v)
      @(posedge clk);
      pwrTrig <= 4'hF;
      repeat (10) @(posedge clk);
      #1 `CHK("masked power", 3'h0, pwrRst)
      // seen bits: 0 pin low, 1 standby, 2 core, 3 watchdog; the pin stays high here
      rd(rtc_pkg::OFS_TRIG_SEEN, v); `CHK("seen log", 4'hE, v[3:0])
      @(posedge clk);
      pwrTrig <= 4'h7;
      #1 `CHK("por unmaskable", 3'h7, pwrRst)
      @(posedge clk);
      pwrTrig <= 4'h8;
      wait_idle();
      rd(rtc_pkg::OFS_MON_CTRL, v); `CHK("mon restored", rtc_pkg::MON_CTRL_RST, v)
   endtask

   task automatic end_sim();
      $display("compares %0d failCount %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // the power-on conduction only starts after the resync delay
      repeat (4) @(posedge clk);
      wait_idle();
      `CHK("reset flow level", 3'h1, lastLvl)
      t_regs();
      t_sw_reg();
      t_user_prio();
      t_pwr(3, 3'h7, 3'h1);
      t_pwr(2, 3'h6, 3'h2);
      t_pwr(1, 3'h4, 3'h3);
      t_pwr(0, 3'h6, 3'h2);
      t_mask();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      $display("ERROR watchdog expected done seen hang");
      end_sim();
   end
endmodule

`default_nettype wire
